// ---- rtl/bew_top.sv ----
// Boot command interpreter: encrypted write acceptance, data packet parsing, cancel, response timing
// Assumes link bytes, engine strobes and register port are synchronous to clk
// Functional notes
// R1 - Refuse encrypted write under permanent block protection
// R2 - Refuse when swap flag and protect bit zero
// R3 - Locked protected area is never rewritten
// R4 - Host sends protected before protection data
// R5 - Certificate update refused when certificate area protected
// R6 - Host loads external driver before external access
// R7 - Unallocated external addresses are rejected, unguaranteed
// R8 - Acceptance failure leaves all device state unchanged
// R9 - Success may lock boot; decrypt fail lowers
// R10 - Error packet ends command, back to idle
// R11 - Error packet bytes 81 00 01 FF 00 03
// R12 - Read cancel uses same error packet
// R13 - Setup step one within 137/2773 ms
// R14 - Setup step two within 82 ms
// R15 - Lifecycle and protection commands answer within 3 s
// R16 - Missing end marker: packet error, top priority
`timescale 1ns/1ps
`include "bew_map.svh"
module bew_top #(
  parameter int unsigned SETUP_MAIN_CYC = `BEW_T_SETUP_MAIN_MS * (`BEW_CLK_HZ / 1000),
  parameter int unsigned SETUP_FAST_CYC = `BEW_T_SETUP_FAST_MS * (`BEW_CLK_HZ / 1000),
  parameter int unsigned SETUP2_CYC     = `BEW_T_SETUP2_MS * (`BEW_CLK_HZ / 1000),
  parameter int unsigned RESP_CYC       = `BEW_T_RESP_S * `BEW_CLK_HZ
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            nrst,
  // Register port
  input  wire logic [3:0]      addr,
  input  wire logic [15:0]     wdata,
  input  wire logic            wr,
  input  wire logic            rd,
  output logic      [15:0]     rdata,
  // Host link bytes and responses
  input  wire logic            rx_valid,
  input  wire logic [7:0]      rx_byte,
  output logic                 resp_valid,
  output logic      [7:0]      resp_code,
  // Flash write stream
  output logic                 fwr_valid,
  output bew_pkg::bew_fwr_t    fwr,
  // Engine strobes
  input  wire logic            eng_done,
  input  wire logic            decrypt_init_fail,
  input  wire logic            setup_step_done,
  // Device state and interrupt
  output logic                 locked_boot_state,
  output logic                 lowest_protection_level,
  output logic                 irq
);
  import bew_pkg::*;

  logic [1:0]  sync_r;
  logic        rst_n;
  bew_cfg_t    cfg_r;
  logic [3:0]  mask_r, stat_r;
  logic [15:0] rdata_r, len_r, cnt_r;
  bew_st_t     st_r, st_nxt;
  bew_ph_t     ph_r;
  logic [2:0]  cmd_r;
  logic [7:0]  sum_r, code_r, area_err_r, ev_code, resp_code_r;
  logic [1:0]  area_r;
  logic [31:0] tmr_r, lim;
  logic        first_r, fmt_bad_r, pbp_seen_r, dif_seen_r;
  logic        tmr_hit, timed, cmd_wr, ev_valid;
  logic        cancel_ev, tmo_ev, last_ev, start_ev;
  logic        resp_valid_r, fwr_valid_r, locked_r, prot_low_r;
  bew_fwr_t    fwr_r;

  // Release of the asynchronous reset is retimed so every flop on rst_n leaves reset on the same edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) sync_r <= 2'b00;
    else sync_r <= {sync_r[0], 1'b1};
  end
  assign rst_n = sync_r[1];
  function automatic logic [7:0] area_check(input logic [1:0] ar, input bew_cfg_t c, input logic seen);
    logic [7:0] r;
    r = `BEW_R_OK;
    if (ar == `BEW_AR_PROT && (c.lock_bit || seen)) r = `BEW_R_PROT; // R3 R4
    if (ar == `BEW_AR_EXT && (!c.driver_loaded || !c.ext_alloc)) r = `BEW_R_FACC; // R6 R7
    return r;
  endfunction : area_check
  assign cmd_wr = wr && addr == `BEW_A_CMD;
  assign timed  = st_r == BEW_WAIT || st_r == BEW_SETUP1 || st_r == BEW_SETUP2;

  always_comb begin
    lim = RESP_CYC; // R15
    if (st_r == BEW_SETUP1) lim = cfg_r.internal_fast_oscillator ? SETUP_FAST_CYC : SETUP_MAIN_CYC; // R13
    if (st_r == BEW_SETUP2) lim = SETUP2_CYC; // R14
  end
  // Compare is not exact so a limit lowered mid-phase still ends the phase
  assign tmr_hit = timed && tmr_r >= lim - 32'h1;

  // Decision of the next phase and of the response to send
  always_comb begin
    st_nxt    = st_r;
    ev_valid  = 1'b0;
    ev_code   = `BEW_R_OK;
    cancel_ev = 1'b0;
    tmo_ev    = 1'b0;
    last_ev   = 1'b0;
    start_ev  = 1'b0;
    unique case (st_r)
      BEW_IDLE: begin
        if (cmd_wr) begin
          start_ev = 1'b1;
          case (wdata[2:0])
            `BEW_C_ENC_WR: begin
              if (cfg_r.permanent_block_protect) begin // R1
                ev_valid = 1'b1;
                ev_code  = `BEW_R_PROT;
              end else if (!cfg_r.boot_swap_flag && !cfg_r.flash_protect_bit) begin // R2
                ev_valid = 1'b1;
                ev_code  = `BEW_R_PROT;
              end else st_nxt = BEW_DATA;
            end
            `BEW_C_CERT: begin
              if (cfg_r.cert_pbp) begin // R5
                ev_valid = 1'b1;
                ev_code  = `BEW_R_PROT;
              end else st_nxt = BEW_DATA;
            end
            `BEW_C_LC_TR, `BEW_C_LC_RQ, `BEW_C_PL_TR: st_nxt = BEW_WAIT;
            `BEW_C_SETUP: st_nxt = BEW_SETUP1;
            default: begin
              ev_valid = 1'b1;
              ev_code  = `BEW_R_ACC;
            end
          endcase
        end
      end
      BEW_DATA: begin
        if (rx_valid && ph_r == BEW_P_END) begin
          ev_valid = 1'b1;
          st_nxt   = BEW_IDLE;
          if (rx_byte != `BEW_B_END) ev_code = `BEW_R_PKT; // R16
          else if (sum_r != 8'h00) ev_code = `BEW_R_SUM;
          else if (fmt_bad_r) ev_code = `BEW_R_PKT;
          else if (code_r == `BEW_B_ERR && len_r == `BEW_LEN_ERR) begin // R10 R11 R12
            ev_code   = `BEW_R_CANCEL;
            cancel_ev = 1'b1;
          end else if (area_err_r != `BEW_R_OK) ev_code = area_err_r;
          else if (code_r == `BEW_B_LAST) last_ev = 1'b1; // R9
          else st_nxt = BEW_DATA;
        end
      end
      BEW_WAIT, BEW_SETUP2: begin
        if (eng_done && st_r == BEW_WAIT || setup_step_done && st_r == BEW_SETUP2) begin
          ev_valid = 1'b1;
          st_nxt   = BEW_IDLE;
        end else if (tmr_hit) begin // R14 R15
          ev_valid = 1'b1;
          ev_code  = `BEW_R_TMO;
          tmo_ev   = 1'b1;
          st_nxt   = BEW_IDLE;
        end
      end
      BEW_SETUP1: begin
        if (setup_step_done) st_nxt = BEW_SETUP2;
        else if (tmr_hit) begin // R13
          ev_valid = 1'b1;
          ev_code  = `BEW_R_TMO;
          tmo_ev   = 1'b1;
          st_nxt   = BEW_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st_r <= BEW_IDLE;
    else st_r <= st_nxt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cmd_r <= 3'h0;
    else if (start_ev) cmd_r <= wdata[2:0];
  end

  // Response timers restart on every phase change, so each step gets its own full limit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tmr_r <= 32'h0;
    else if (!timed || st_nxt != st_r) tmr_r <= 32'h0;
    else tmr_r <= tmr_r + 32'h1;
  end

  // Packet parser; stray bytes before a start byte are dropped to resynchronise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r       <= BEW_P_START;
      len_r      <= 16'h0;
      cnt_r      <= 16'h0;
      sum_r      <= 8'h0;
      code_r     <= 8'h0;
      area_r     <= 2'h0;
      area_err_r <= `BEW_R_OK;
      first_r    <= 1'b0;
      fmt_bad_r  <= 1'b0;
    end else if (st_r != BEW_DATA) ph_r <= BEW_P_START;
    else if (rx_valid) begin
      unique case (ph_r)
        BEW_P_START: if (rx_byte == `BEW_B_START) begin
          ph_r       <= BEW_P_LENH;
          area_err_r <= `BEW_R_OK;
        end
        BEW_P_LENH: begin
          len_r[15:8] <= rx_byte;
          sum_r       <= rx_byte;
          ph_r        <= BEW_P_LENL;
        end
        BEW_P_LENL: begin
          len_r[7:0] <= rx_byte;
          sum_r      <= sum_r + rx_byte;
          ph_r       <= BEW_P_CODE;
        end
        BEW_P_CODE: begin
          code_r    <= rx_byte;
          sum_r     <= sum_r + rx_byte;
          fmt_bad_r <= len_r == 16'h0;
          cnt_r     <= len_r - 16'h1;
          first_r   <= 1'b1;
          ph_r      <= (len_r <= 16'h1) ? BEW_P_SUM : BEW_P_DAT;
        end
        BEW_P_DAT: begin
          sum_r   <= sum_r + rx_byte;
          first_r <= 1'b0;
          cnt_r   <= cnt_r - 16'h1;
          if (first_r) begin
            area_r     <= rx_byte[1:0];
            area_err_r <= area_check(rx_byte[1:0], cfg_r, pbp_seen_r); // R3 R4 R6 R7
          end
          if (cnt_r == 16'h1) ph_r <= BEW_P_SUM;
        end
        BEW_P_SUM: begin
          sum_r <= sum_r + rx_byte;
          ph_r  <= BEW_P_END;
        end
        BEW_P_END: ph_r <= BEW_P_START;
      endcase
    end
  end

  // Data reaches flash only after acceptance and only for an area that passed its check
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fwr_valid_r <= 1'b0;
      fwr_r       <= '0;
    end else begin
      fwr_valid_r <= st_r == BEW_DATA && rx_valid && ph_r == BEW_P_DAT && !first_r &&
                     area_err_r == `BEW_R_OK; // R8 R3
      if (rx_valid) fwr_r <= '{area: area_r, data: rx_byte};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pbp_seen_r <= 1'b0;
      dif_seen_r <= 1'b0;
    end else if (start_ev) begin
      pbp_seen_r <= 1'b0;
      // A failure reported in the start cycle is kept: set wins over clear
      dif_seen_r <= decrypt_init_fail;
    end else begin
      if (st_r == BEW_DATA && rx_valid && ph_r == BEW_P_DAT && first_r && rx_byte[1:0] == `BEW_AR_PBP)
        pbp_seen_r <= 1'b1; // R4
      if (decrypt_init_fail) dif_seen_r <= 1'b1;
    end
  end

  // Lifecycle and protection level change only on a completed encrypted write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      locked_r   <= 1'b0;
      prot_low_r <= 1'b0;
    end else if (last_ev && cmd_r == `BEW_C_ENC_WR) begin
      if (cfg_r.transition_pattern) locked_r <= 1'b1; // R9
      if (dif_seen_r || decrypt_init_fail) prot_low_r <= 1'b1; // R9
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid_r <= 1'b0;
      resp_code_r  <= `BEW_R_OK;
    end else begin
      resp_valid_r <= ev_valid;
      if (ev_valid) resp_code_r <= ev_code;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r  <= `BEW_CFG_RST;
      mask_r <= `BEW_MASK_RST;
    end else if (wr) begin
      if (addr == `BEW_A_CFG) cfg_r <= wdata[8:0];
      if (addr == `BEW_A_MASK) mask_r <= wdata[3:0];
    end
  end

  // A read clears status, but an event in the same cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) stat_r <= 4'h0;
    else begin
      stat_r <= (rd && addr == `BEW_A_STAT) ? 4'h0 : stat_r;
      if (ev_valid) stat_r[`BEW_S_RESP] <= 1'b1;
      if (ev_valid && ev_code != `BEW_R_OK) stat_r[`BEW_S_ERR] <= 1'b1;
      if (cancel_ev) stat_r[`BEW_S_CANCEL] <= 1'b1;
      if (tmo_ev) stat_r[`BEW_S_TMO] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata_r <= 16'h0;
    else if (rd) begin
      unique case (addr)
        `BEW_A_CFG:   rdata_r <= {7'h0, cfg_r};
        `BEW_A_STAT:  rdata_r <= {12'h0, stat_r};
        `BEW_A_MASK:  rdata_r <= {12'h0, mask_r};
        `BEW_A_STATE: rdata_r <= {6'h0, prot_low_r, locked_r, 1'b0, ph_r, 1'b0, st_r};
        `BEW_A_RESP:  rdata_r <= {8'h0, resp_code_r};
        default:      rdata_r <= 16'h0;
      endcase
    end else rdata_r <= 16'h0;
  end

  assign rdata                   = rdata_r;
  assign resp_valid              = resp_valid_r;
  assign resp_code               = resp_code_r;
  assign fwr_valid               = fwr_valid_r;
  assign fwr                     = fwr_r;
  assign locked_boot_state       = locked_r;
  assign lowest_protection_level = prot_low_r;
  assign irq                     = |(stat_r & mask_r);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic enc_go;
  assign enc_go = st_r == BEW_IDLE && cmd_wr && wdata[2:0] == `BEW_C_ENC_WR;
  enc_pbp_a: assert property (enc_go && cfg_r.permanent_block_protect |=> // R1
    resp_valid && resp_code == `BEW_R_PROT && st_r == BEW_IDLE) else $error("protected write accepted");
  enc_flags_a: assert property (enc_go && !cfg_r.boot_swap_flag && !cfg_r.flash_protect_bit |=> // R2
    st_r == BEW_IDLE && resp_code == `BEW_R_PROT) else $error("flagless write accepted");
  lock_write_a: assert property (fwr_valid |-> !(fwr.area == `BEW_AR_PROT && cfg_r.lock_bit)) // R3
    else $error("locked area written");
  cert_refuse_a: assert property (st_r == BEW_IDLE && cmd_wr && wdata[2:0] == `BEW_C_CERT && // R5
    cfg_r.cert_pbp |=> st_r == BEW_IDLE ##0 resp_valid) else $error("certificate update accepted");
  accept_write_a: assert property (fwr_valid |-> $past(st_r) == BEW_DATA) // R8
    else $error("write outside accepted command");
  lock_boot_a: assert property (last_ev && cmd_r == `BEW_C_ENC_WR && cfg_r.transition_pattern |=> // R9
    locked_boot_state && resp_code == `BEW_R_OK) else $error("lock state missed");
  cancel_idle_a: assert property (cancel_ev |=> st_r == BEW_IDLE && resp_code == `BEW_R_CANCEL && // R10
    stat_r[`BEW_S_CANCEL]) else $error("cancel not honoured");
  setup_bound_a: assert property (st_r == BEW_SETUP1 |-> tmr_r < lim) // R13
    else $error("setup limit passed");
  setup2_tmo_a: assert property (st_r == BEW_SETUP2 && tmr_hit && !setup_step_done |=> // R14
    resp_valid && resp_code == `BEW_R_TMO) else $error("second setup timeout lost");
  resp_tmo_a: assert property (st_r == BEW_WAIT && tmr_hit && !eng_done |=> // R15
    resp_valid && resp_code == `BEW_R_TMO ##1 st_r == BEW_IDLE) else $error("response limit passed");
  end_first_a: assert property (st_r == BEW_DATA && rx_valid && ph_r == BEW_P_END && // R16
    rx_byte != `BEW_B_END |=> resp_code == `BEW_R_PKT && st_r == BEW_IDLE) else $error("end marker miss");
  enc_done_c: cover property (last_ev && cmd_r == `BEW_C_ENC_WR);
  cancel_c: cover property (cancel_ev);
  tmo_c: cover property (tmo_ev);
  irq_c: cover property (irq ##1 !irq);
endmodule : bew_top

// ---- include/bew_map.svh ----
// Offsets, field positions, reset values, codes and timing figures of the encrypted write interpreter
// Included by the package user; definitions only
`ifndef BEW_MAP_SVH
`define BEW_MAP_SVH
`define BEW_A_CMD        4'h0
`define BEW_A_CFG        4'h1
`define BEW_A_STAT       4'h2
`define BEW_A_MASK       4'h3
`define BEW_A_STATE      4'h4
`define BEW_A_RESP       4'h5
`define BEW_CFG_RST      9'h000
`define BEW_MASK_RST     4'h0
`define BEW_C_ENC_WR     3'h1
`define BEW_C_CERT       3'h2
`define BEW_C_LC_TR      3'h3
`define BEW_C_LC_RQ      3'h4
`define BEW_C_PL_TR      3'h5
`define BEW_C_SETUP      3'h6
`define BEW_B_START      8'h81
`define BEW_B_END        8'h03
`define BEW_B_ERR        8'hFF
`define BEW_B_LAST       8'h01
`define BEW_LEN_ERR      16'h0001
`define BEW_AR_PROT      2'h1
`define BEW_AR_PBP       2'h2
`define BEW_AR_EXT       2'h3
`define BEW_R_OK         8'h00
`define BEW_R_PKT        8'hC1
`define BEW_R_SUM        8'hC2
`define BEW_R_ACC        8'hC3
`define BEW_R_PROT       8'hDA
`define BEW_R_FACC       8'hE1
`define BEW_R_TMO        8'hEF
`define BEW_R_CANCEL     8'hFF
`define BEW_S_RESP       0
`define BEW_S_ERR        1
`define BEW_S_CANCEL     2
`define BEW_S_TMO        3
`define BEW_CLK_HZ       20000000
`define BEW_T_SETUP_MAIN_MS 137
`define BEW_T_SETUP_FAST_MS 2773
`define BEW_T_SETUP2_MS  82
`define BEW_T_RESP_S     3
`endif

// ---- include/bew_pkg.sv ----
// Types shared by the encrypted write interpreter
// Constants live in bew_map.svh
package bew_pkg;
  typedef struct packed {
    logic transition_pattern;
    logic internal_fast_oscillator;
    logic ext_alloc;
    logic driver_loaded;
    logic cert_pbp;
    logic lock_bit;
    logic permanent_block_protect;
    logic flash_protect_bit;
    logic boot_swap_flag;
  } bew_cfg_t;
  typedef struct packed {
    logic [1:0] area;
    logic [7:0] data;
  } bew_fwr_t;
  typedef enum logic [2:0] {BEW_IDLE, BEW_DATA, BEW_WAIT, BEW_SETUP1, BEW_SETUP2} bew_st_t;
  typedef enum logic [2:0] {BEW_P_START, BEW_P_LENH, BEW_P_LENL, BEW_P_CODE, BEW_P_DAT, BEW_P_SUM, BEW_P_END} bew_ph_t;
endpackage : bew_pkg

// ---- tb/bew_host.sv ----
// Host tool model: frames link packets onto the byte strobe of the interpreter
// Assumes one caller at a time; bytes change only just after a rising clk
`timescale 1ns/1ps
module bew_host (
  // Clock
  input  wire logic       clk,
  // Link bytes
  output logic            rx_valid,
  output logic [7:0]      rx_byte
);
  int gap = 0;
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end
  // Idle line toggles away from the last byte so a stale copy never looks valid
  task automatic put(input logic [7:0] b);
    repeat (gap) begin
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_byte  <= ~rx_byte;
    end
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_byte  <= b;
  endtask : put
  // Body of n bytes: area code first, then d0 counting up; bad[0] spoils sum, bad[1] end marker
  task automatic send(input logic [7:0] rcode, input logic [7:0] area, input int n, input logic [7:0] d0,
                      input logic [1:0] bad);
    logic [15:0] len;
    logic [7:0]  sum;
    logic [7:0]  b;
    len = 16'(n + 1);
    sum = len[15:8] + len[7:0] + rcode;
    put(8'h81);
    put(len[15:8]);
    put(len[7:0]);
    put(rcode);
    for (int i = 0; i < n; i++) begin
      b = (i == 0) ? area : d0 + 8'(i - 1);
      sum = sum + b;
      put(b);
    end
    put(8'h00 - sum + {7'h00, bad[0]});
    put(bad[1] ? 8'h04 : 8'h03);
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_byte  <= ~rx_byte;
  endtask : send
endmodule : bew_host

// ---- tb/boot_encrypted_write_and_cancel_bench.sv ----
// Self-checking bench for the encrypted write interpreter
// Drives the register port and engine strobes; link bytes come from the host model
`timescale 1ns/1ps
`include "bew_map.svh"
module boot_encrypted_write_and_cancel_bench;
  import bew_pkg::*;
  // Short limits keep the run brief; only the second setup step timeout wait below is derived from them
  localparam int unsigned LIM1 = 20;
  localparam int unsigned LIMF = 40;
  localparam int unsigned LIM2 = 10;
  localparam int unsigned LIMR = 30;
  typedef struct packed {
    logic [8:0] cfg;
    logic [2:0] cmd;
    logic       eng;
    logic [7:0] lim;
    logic [7:0] code;
  } bew_row_t;
  logic        clk, nrst, wr, rd, rx_valid, resp_valid, fwr_valid, locked_boot_state, lowest_protection_level, irq;
  logic [2:0]  stb;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata;
  logic [7:0]  rx_byte, resp_code;
  bew_fwr_t    fwr;
  logic [7:0]  resp_q[$];
  bew_fwr_t    fwr_q[$];
  int          n_fail = 0;
  int          check_count = 0;
  bew_row_t    rows [8] = '{
    '{9'h000, `BEW_C_ENC_WR, 1'b0, 8'h04, `BEW_R_PROT},
    '{9'h005, `BEW_C_ENC_WR, 1'b0, 8'h04, `BEW_R_PROT},
    '{9'h011, `BEW_C_CERT,   1'b0, 8'h04, `BEW_R_PROT},
    '{9'h001, 3'h7,          1'b0, 8'h04, `BEW_R_ACC},
    '{9'h001, `BEW_C_LC_TR,  1'b1, 8'h06, `BEW_R_OK},
    '{9'h001, `BEW_C_LC_RQ,  1'b0, 8'h22, `BEW_R_TMO},
    '{9'h001, `BEW_C_PL_TR,  1'b1, 8'h06, `BEW_R_OK},
    '{9'h000, `BEW_C_SETUP,  1'b0, 8'h18, `BEW_R_TMO}
  };
  bew_top #(.SETUP_MAIN_CYC(LIM1), .SETUP_FAST_CYC(LIMF), .SETUP2_CYC(LIM2), .RESP_CYC(LIMR)) dut (
    .clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .rx_valid, .rx_byte, .resp_valid, .resp_code,
    .fwr_valid, .fwr, .eng_done(stb[0]), .decrypt_init_fail(stb[1]), .setup_step_done(stb[2]),
    .locked_boot_state, .lowest_protection_level, .irq);
  bew_host host (.clk, .rx_valid, .rx_byte);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pulses are one cycle wide, so they are captured at the edge they stand in
  always @(posedge clk) begin
    if (resp_valid === 1'b1) resp_q.push_back(resp_code);
    if (fwr_valid === 1'b1) fwr_q.push_back(fwr);
  end
  task automatic stop_test();
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("register", e, rdata);
  endtask : rchk
  task automatic start(input logic [8:0] c, input logic [2:0] k);
    reg_wr(`BEW_A_CFG, {7'h00, c});
    reg_wr(`BEW_A_CMD, {13'h0000, k});
  endtask : start
  task automatic pulse(input int d, input int s);
    repeat (d) @(posedge clk);
    stb[s] <= 1'b1;
    @(posedge clk);
    stb[s] <= 1'b0;
  endtask : pulse
  task automatic exp_resp(input int lim, input logic [7:0] e);
    int c = 0;
    while (resp_q.size() == 0 && c < lim) begin
      @(posedge clk);
      c++;
    end
    chk("resp_code", {8'h00, e}, (resp_q.size() > 0) ? {8'h00, resp_q.pop_front()} : 16'hXXXX);
  endtask : exp_resp
  task automatic exp_fwr(input logic [1:0] ar, input logic [7:0] d0, input int n);
    for (int i = 0; i < n; i++)
      chk("fwr", {6'h00, ar, d0 + 8'(i)}, (fwr_q.size() > 0) ? {6'h00, fwr_q.pop_front()} : 16'hXXXX);
    chk("fwr_left", 16'h0000, 16'(fwr_q.size()));
  endtask : exp_fwr
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial begin
    nrst = 1'b0;
    {wr, rd, addr, wdata, stb} = '0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(`BEW_A_CFG, 16'h0000);
    rchk(`BEW_A_MASK, 16'h0000);
    rchk(4'hF, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      start(rows[i].cfg, rows[i].cmd);
      if (rows[i].eng === 1'b1) pulse(2, 0);
      exp_resp(int'(rows[i].lim), rows[i].code);
      rchk(`BEW_A_STATE, 16'h0000);
      exp_fwr(2'h0, 8'h00, 0);
    end
    // Status is sticky but masked: line stays low until the mask opens
    chk("irq", 16'h0000, {15'h0000, irq});
    reg_wr(`BEW_A_MASK, 16'h0008);
    #1 chk("irq", 16'h0001, {15'h0000, irq});
    rchk(`BEW_A_MASK, 16'h0008);
    rchk(`BEW_A_STAT, 16'h000B);
    #1 chk("irq", 16'h0000, {15'h0000, irq});
    start(9'h001, `BEW_C_ENC_WR);
    host.send(8'h00, 8'h01, 3, 8'hAA, 2'h0);
    exp_resp(4, `BEW_R_OK);
    exp_fwr(2'h1, 8'hAA, 2);
    host.send(8'h00, 8'h00, 1, 8'h00, 2'h3);
    exp_resp(4, `BEW_R_PKT);
    rchk(`BEW_A_STATE, 16'h0000);
    start(9'h001, `BEW_C_ENC_WR);
    host.send(8'h00, 8'h00, 1, 8'h00, 2'h1);
    exp_resp(4, `BEW_R_SUM);
    start(9'h009, `BEW_C_ENC_WR);
    host.send(8'h00, 8'h01, 2, 8'h22, 2'h0);
    exp_resp(4, `BEW_R_PROT);
    exp_fwr(2'h0, 8'h00, 0);
    start(9'h001, `BEW_C_ENC_WR);
    host.send(8'h00, 8'h02, 2, 8'h33, 2'h0);
    exp_resp(4, `BEW_R_OK);
    exp_fwr(2'h2, 8'h33, 1);
    host.send(8'h00, 8'h01, 2, 8'h44, 2'h0);
    exp_resp(4, `BEW_R_PROT);
    exp_fwr(2'h0, 8'h00, 0);
    start(9'h001, `BEW_C_ENC_WR);
    host.send(8'h00, 8'h03, 2, 8'h50, 2'h0);
    exp_resp(4, `BEW_R_FACC);
    start(9'h021, `BEW_C_ENC_WR);
    host.send(8'h00, 8'h03, 2, 8'h51, 2'h0);
    exp_resp(4, `BEW_R_FACC);
    start(9'h061, `BEW_C_ENC_WR);
    host.gap = 2;
    host.send(8'h00, 8'h03, 2, 8'h55, 2'h0);
    host.gap = 0;
    exp_resp(4, `BEW_R_OK);
    exp_fwr(2'h3, 8'h55, 1);
    host.send(8'hFF, 8'h00, 0, 8'h00, 2'h0);
    exp_resp(4, `BEW_R_CANCEL);
    rchk(`BEW_A_STATE, 16'h0000);
    rchk(`BEW_A_RESP, 16'h00FF);
    rchk(`BEW_A_STAT, 16'h0007);
    // Step one lands past the main limit but inside the fast one
    start(9'h080, `BEW_C_SETUP);
    pulse(30, 2);
    pulse(5, 2);
    exp_resp(4, `BEW_R_OK);
    start(9'h000, `BEW_C_SETUP);
    pulse(5, 2);
    exp_resp(LIM2 + 4, `BEW_R_TMO);
    start(9'h101, `BEW_C_ENC_WR);
    pulse(1, 1);
    host.send(8'h00, 8'h01, 2, 8'h66, 2'h0);
    exp_resp(4, `BEW_R_OK);
    exp_fwr(2'h1, 8'h66, 1);
    host.send(8'h01, 8'h02, 2, 8'h77, 2'h0);
    exp_resp(4, `BEW_R_OK);
    exp_fwr(2'h2, 8'h77, 1);
    chk("dev_state", 16'h0003, {14'h0000, locked_boot_state, lowest_protection_level});
    rchk(`BEW_A_STATE, 16'h0300);
    reg_wr(`BEW_A_MASK, 16'h000F);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("reset_out", 16'h0000, {11'h000, locked_boot_state, lowest_protection_level, irq, resp_valid, fwr_valid});
    @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(`BEW_A_CFG, 16'h0000);
    rchk(`BEW_A_MASK, 16'h0000);
    rchk(`BEW_A_STATE, 16'h0000);
    stop_test();
  end
endmodule : boot_encrypted_write_and_cancel_bench
